// ===== hvcbl_pkg.sv
// Contract
// - Buffer address, decode one select per latch
// - Any own address pulls acknowledge low
// - Eight data bits feed all four latches
// - Latch loads on write strobe with address
// - Power-on clear empties every latch
// - Relay latch bit drives one relay
// - Four control bits become tap selects
// - One control bit selects zero-amp gain
// - Gain select on means 100, off 1000
// - Drive enable passes drive, blocks zero relay
// - Oscillator held in reset outside high voltage
// - Two auxiliary bits drive auxiliary relays
// - Four mux bits select monitor source
// - Read strobe at revision address drives strap
// - Positive polarity: relay off, driver high
package hvcbl_pkg;

	// ====================================================================
	// Bus widths
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int NUM_LATCH = 4;

	// ====================================================================
	// Board addresses (chosen decode points on the guarded bus)
	localparam logic [ADDR_W-1:0] ADDR_RELAY = 7'h50;
	localparam logic [ADDR_W-1:0] ADDR_CTRL  = 7'h51;
	localparam logic [ADDR_W-1:0] ADDR_AUX   = 7'h52;
	localparam logic [ADDR_W-1:0] ADDR_MUX   = 7'h53;
	localparam logic [ADDR_W-1:0] ADDR_REV   = 7'h54;

	// Latch indices
	localparam int LAT_RELAY = 0;
	localparam int LAT_CTRL  = 1;
	localparam int LAT_AUX   = 2;
	localparam int LAT_MUX   = 3;

	// ====================================================================
	// Field positions
	localparam int RELAY_POLARITY_BIT = 0;
	localparam int CTRL_TAP_LSB       = 0;
	localparam int TAP_W              = 4;
	localparam int CTRL_ZERO_GAIN_BIT = 4;
	localparam int CTRL_HV_DRIVE_BIT  = 5;
	localparam int CTRL_OSC_RUN_BIT   = 6;
	localparam int AUX_W              = 2;
	localparam int MUX_W              = 4;

	// Clear value of every latch
	localparam logic [DATA_W-1:0] LATCH_CLEAR = 8'h00;

	// ====================================================================
	// Sampled bus pins travelling together
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              wr_n;
		logic              rd_n;
		logic              clr_n;
	} hvcbl_bus_t;

	localparam hvcbl_bus_t BUS_IDLE = '{addr: 7'h00, data: 8'h00,
		wr_n: 1'b1, rd_n: 1'b1, clr_n: 1'b1};

endpackage

// ===== hvcbl_latch.sv
`timescale 1ns/1ps
// Eight-bit output latch with load enable and clear
module hvcbl_latch
	import hvcbl_pkg::*;
(
	// Clock and reset
	input  wire logic                         i_sys_clk,
	input  wire logic                         i_rst_n,
	// Control
	input  wire logic                         i_load,
	input  wire logic                         i_clear,
	input  wire logic [hvcbl_pkg::DATA_W-1:0] i_data,
	// Stored value
	output logic      [hvcbl_pkg::DATA_W-1:0] o_q
);

	import hvcbl_pkg::*;

	logic [DATA_W-1:0] q_reg;
	logic [DATA_W-1:0] q_next;

	// ====================================================================
	// Next value: clear beats load, otherwise hold
	always_comb
	begin
		q_next = q_reg;
		if (i_clear)
			q_next = LATCH_CLEAR;
		else if (i_load)
			q_next = i_data;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
			q_reg <= LATCH_CLEAR;
		else
			q_reg <= q_next;
	end

	assign o_q = q_reg;

endmodule

// ===== hvcbl_top.sv
`timescale 1ns/1ps
// Control-latch board on the guarded parallel bus
module hvcbl_top
	import hvcbl_pkg::*;
(
	// Clock and reset
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_rst_n,
	// Guarded bus from the main processor (asynchronous pins)
	input  wire logic [hvcbl_pkg::ADDR_W-1:0] i_guarded_addr,
	input  wire logic [hvcbl_pkg::DATA_W-1:0] i_guarded_data,
	input  wire logic                       i_guarded_write_strobe_n,
	input  wire logic                       i_guarded_read_strobe_n,
	input  wire logic                       i_guarded_power_on_clear_n,
	// Revision straps
	input  wire logic [hvcbl_pkg::DATA_W-1:0] i_rev_strap,
	// Bus answer: open-drain acknowledge and read data
	output logic                            o_ack_n_out,
	output logic                            o_ack_oe,
	output logic [hvcbl_pkg::DATA_W-1:0]    o_data_out,
	output logic                            o_data_oe,
	// Output amplifier relays (driver low energizes)
	output logic [hvcbl_pkg::DATA_W-1:0]    o_relay_drive_n,
	// High-voltage supply
	output logic [hvcbl_pkg::TAP_W-1:0]     o_tap_select,
	output logic                            o_zero_amp_gain_select,
	output logic                            o_hv_drive_enable,
	output logic                            o_zero_input_relay_block,
	output logic                            o_osc_reset_n,
	// Auxiliary relays and monitor mux
	output logic [hvcbl_pkg::AUX_W-1:0]     o_aux_relay_ctl,
	output logic [hvcbl_pkg::MUX_W-1:0]     o_mon_mux_sel
);

	import hvcbl_pkg::*;

	// ====================================================================
	// Decode helper: one-hot select for a given address
	function automatic logic [NUM_LATCH:0] decode_addr(
		input logic [ADDR_W-1:0] addr);
		logic [NUM_LATCH:0] sel;
		sel = '0;
		sel[LAT_RELAY] = (addr == ADDR_RELAY);
		sel[LAT_CTRL]  = (addr == ADDR_CTRL);
		sel[LAT_AUX]   = (addr == ADDR_AUX);
		sel[LAT_MUX]   = (addr == ADDR_MUX);
		sel[NUM_LATCH] = (addr == ADDR_REV);
		return sel;
	endfunction

	// ====================================================================
	// Pin synchronisers: two flops before any logic
	hvcbl_bus_t bus_meta_reg;
	hvcbl_bus_t bus_meta_next;
	hvcbl_bus_t bus_sync_reg;
	hvcbl_bus_t bus_sync_next;
	logic       wr_n_prev_reg;
	logic       wr_n_prev_next;
	logic [DATA_W-1:0] strap_meta_reg;
	logic [DATA_W-1:0] strap_meta_next;
	logic [DATA_W-1:0] strap_sync_reg;
	logic [DATA_W-1:0] strap_sync_next;

	// Sample the pins; only the second stage is read by logic
	always_comb
	begin
		bus_meta_next.addr  = i_guarded_addr;
		bus_meta_next.data  = i_guarded_data;
		bus_meta_next.wr_n  = i_guarded_write_strobe_n;
		bus_meta_next.rd_n  = i_guarded_read_strobe_n;
		bus_meta_next.clr_n = i_guarded_power_on_clear_n;
		bus_sync_next       = bus_meta_reg;
		wr_n_prev_next      = bus_sync_reg.wr_n;
		strap_meta_next     = i_rev_strap;
		strap_sync_next     = strap_meta_reg;
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			bus_meta_reg   <= BUS_IDLE;
			bus_sync_reg   <= BUS_IDLE;
			wr_n_prev_reg  <= 1'b1;
			strap_meta_reg <= LATCH_CLEAR;
			strap_sync_reg <= LATCH_CLEAR;
		end
		else
		begin
			bus_meta_reg   <= bus_meta_next;
			bus_sync_reg   <= bus_sync_next;
			wr_n_prev_reg  <= wr_n_prev_next;
			strap_meta_reg <= strap_meta_next;
			strap_sync_reg <= strap_sync_next;
		end
	end

	// ====================================================================
	// Address decode and write strobe edge
	logic [NUM_LATCH:0] sel;
	logic               any_sel;
	logic               wr_edge;
	logic               clear_now;

	// A latch loads once, on the falling edge of the synced strobe;
	// address and data went through the same two flops, so they line up
	assign sel       = decode_addr(bus_sync_reg.addr);
	assign any_sel   = |sel;
	assign wr_edge   = wr_n_prev_reg & ~bus_sync_reg.wr_n;
	assign clear_now = ~bus_sync_reg.clr_n;

	// ====================================================================
	// The four output latches
	logic [DATA_W-1:0] latch_q [NUM_LATCH];

	genvar gi;
	generate
		for (gi = 0; gi < NUM_LATCH; gi++)
		begin : g_latch
			hvcbl_latch u_latch (
				.i_sys_clk (i_sys_clk),
				.i_rst_n   (i_rst_n),
				.i_load    (wr_edge & sel[gi]),
				.i_clear   (clear_now),
				.i_data    (bus_sync_reg.data),
				.o_q       (latch_q[gi])
			);
		end
	endgenerate

	// ====================================================================
	// Output registers
	logic                ack_oe_reg;
	logic                ack_oe_next;
	logic [DATA_W-1:0]   data_out_reg;
	logic [DATA_W-1:0]   data_out_next;
	logic                data_oe_reg;
	logic                data_oe_next;
	logic [DATA_W-1:0]   relay_n_reg;
	logic [DATA_W-1:0]   relay_n_next;
	logic [TAP_W-1:0]    tap_reg;
	logic [TAP_W-1:0]    tap_next;
	logic                gain_reg;
	logic                gain_next;
	logic                hv_reg;
	logic                hv_next;
	logic                osc_n_reg;
	logic                osc_n_next;
	logic [AUX_W-1:0]    aux_reg;
	logic [AUX_W-1:0]    aux_next;
	logic [MUX_W-1:0]    mux_reg;
	logic [MUX_W-1:0]    mux_next;

	// Pin images of the latches; a cleared latch releases everything
	always_comb
	begin
		ack_oe_next  = any_sel;
		data_oe_next = sel[NUM_LATCH] & ~bus_sync_reg.rd_n;
		data_out_next = data_oe_next ? strap_sync_reg : LATCH_CLEAR;
		// Driver low energizes; cleared bit 0 keeps polarity positive
		relay_n_next = ~latch_q[LAT_RELAY];
		tap_next  = latch_q[LAT_CTRL][CTRL_TAP_LSB +: TAP_W];
		// High means FET on, gain 100; low means gain 1000
		gain_next = latch_q[LAT_CTRL][CTRL_ZERO_GAIN_BIT];
		hv_next   = latch_q[LAT_CTRL][CTRL_HV_DRIVE_BIT];
		// Oscillator may only run while high voltage is selected
		osc_n_next = latch_q[LAT_CTRL][CTRL_OSC_RUN_BIT] & hv_next;
		aux_next  = latch_q[LAT_AUX][AUX_W-1:0];
		mux_next  = latch_q[LAT_MUX][MUX_W-1:0];
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			ack_oe_reg   <= 1'b0;
			data_out_reg <= LATCH_CLEAR;
			data_oe_reg  <= 1'b0;
			relay_n_reg  <= ~LATCH_CLEAR;
			tap_reg      <= '0;
			gain_reg     <= 1'b0;
			hv_reg       <= 1'b0;
			osc_n_reg    <= 1'b0;
			aux_reg      <= '0;
			mux_reg      <= '0;
		end
		else
		begin
			ack_oe_reg   <= ack_oe_next;
			data_out_reg <= data_out_next;
			data_oe_reg  <= data_oe_next;
			relay_n_reg  <= relay_n_next;
			tap_reg      <= tap_next;
			gain_reg     <= gain_next;
			hv_reg       <= hv_next;
			osc_n_reg    <= osc_n_next;
			aux_reg      <= aux_next;
			mux_reg      <= mux_next;
		end
	end

	// ====================================================================
	// Ports; the acknowledge only ever pulls low
	assign o_ack_n_out              = 1'b0;
	assign o_ack_oe                 = ack_oe_reg;
	assign o_data_out               = data_out_reg;
	assign o_data_oe                = data_oe_reg;
	assign o_relay_drive_n          = relay_n_reg;
	assign o_tap_select             = tap_reg;
	assign o_zero_amp_gain_select   = gain_reg;
	assign o_hv_drive_enable        = hv_reg;
	assign o_zero_input_relay_block = hv_reg;
	assign o_osc_reset_n            = osc_n_reg;
	assign o_aux_relay_ctl          = aux_reg;
	assign o_mon_mux_sel            = mux_reg;

endmodule

// ===== hvcbl_top_monitor.sv
`timescale 1ns/1ps
// ==================================================
// Port checks on the latch board
module hvcbl_top_monitor
	import hvcbl_pkg::*;
(
	// Clock and guarded bus
	input wire logic              i_sys_clk,
	input wire logic              i_rst_n,
	input wire logic [ADDR_W-1:0] i_guarded_addr,
	input wire logic [DATA_W-1:0] i_guarded_data,
	input wire logic              i_guarded_write_strobe_n,
	input wire logic              i_guarded_read_strobe_n,
	input wire logic              i_guarded_power_on_clear_n,
	input wire logic [DATA_W-1:0] i_rev_strap,
	// Answers and controls
	input wire logic              o_ack_n_out,
	input wire logic              o_ack_oe,
	input wire logic [DATA_W-1:0] o_data_out,
	input wire logic              o_data_oe,
	input wire logic [DATA_W-1:0] o_relay_drive_n,
	input wire logic [TAP_W-1:0]  o_tap_select,
	input wire logic              o_hv_drive_enable,
	input wire logic              o_zero_input_relay_block,
	input wire logic              o_osc_reset_n,
	input wire logic [MUX_W-1:0]  o_mon_mux_sel
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// Own decode window, revision place included
	function automatic logic own(input logic [ADDR_W-1:0] a);
		return a >= ADDR_RELAY && a <= ADDR_REV;
	endfunction
	// Strobe falls on the control address
	sequence ctrl_wr;
		$fell(i_guarded_write_strobe_n) && i_guarded_addr == ADDR_CTRL
			&& i_guarded_power_on_clear_n;
	endsequence
	// Clear held long enough to pass the synchroniser
	sequence clr_held;
		!i_guarded_power_on_clear_n [*4];
	endsequence
	AST_ACK: assert property (o_ack_oe == own($past(i_guarded_addr, 3)))
		else $error("ack enable off its decode");
	AST_ACKV: assert property (o_ack_oe |-> !o_ack_n_out)
		else $error("ack not pulled low");
	AST_DOE: assert property (o_data_oe == ($past(i_guarded_addr, 3)
		== ADDR_REV && !$past(i_guarded_read_strobe_n, 3)))
		else $error("read buffer enable wrong");
	AST_DOUT: assert property (o_data_oe |-> o_data_out == i_rev_strap)
		else $error("read data not the straps");
	AST_WR: assert property (ctrl_wr |-> ##5
		o_tap_select == $past(i_guarded_data[3:0], 5))
		else $error("control write not applied");
	AST_CLR: assert property (clr_held |-> ##2 (o_relay_drive_n == 8'hFF
		&& o_tap_select == 4'h0 && o_mon_mux_sel == 4'h0))
		else $error("clear did not empty latches");
	AST_HOLD: assert property ((i_guarded_write_strobe_n
		&& i_guarded_power_on_clear_n) [*6] |=> $stable(o_relay_drive_n)
		&& $stable(o_mon_mux_sel))
		else $error("latch moved without strobe");
	AST_ZRB: assert property (o_zero_input_relay_block == o_hv_drive_enable)
		else $error("zero relay block differs");
	AST_OSC: assert property (!o_hv_drive_enable |-> !o_osc_reset_n)
		else $error("oscillator runs outside high voltage");
endmodule
bind hvcbl_top hvcbl_top_monitor i_mon (.*);

// ===== hvcbl_host_model.sv
`timescale 1ns/1ps
// ==================================================
// Main processor side of the guarded bus
module hvcbl_host_model
	import hvcbl_pkg::*;
(
	// Clock and bus answer
	input  wire logic              i_sys_clk,
	input  wire logic              i_ack_n,
	input  wire logic [DATA_W-1:0] i_bus_data,
	// Guarded bus pins
	output hvcbl_bus_t             o_bus
);
	initial o_bus = BUS_IDLE;
	// Address and data settle before the strobe and stay through it
	task automatic xfer(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic wr,
		output logic [DATA_W-1:0] q, output logic ok);
		int n;
		n = 0;
		o_bus.addr <= a;
		o_bus.data <= d;
		repeat (3) @(posedge i_sys_clk);
		if (wr) o_bus.wr_n <= 1'b0;
		else o_bus.rd_n <= 1'b0;
		// Bounded wait; an unmapped place never answers
		while (i_ack_n !== 1'b0 && n < 8)
		begin
			@(posedge i_sys_clk);
			n++;
		end
		repeat (5) @(posedge i_sys_clk);
		q = i_bus_data;
		ok = n < 8;
		o_bus.wr_n <= 1'b1;
		o_bus.rd_n <= 1'b1;
		repeat (3) @(posedge i_sys_clk);
		// Released data lines show the inverse, not a stale value; address returns to idle
		o_bus.data <= ~d;
		o_bus.addr <= BUS_IDLE.addr;
		// Let an edge pass so a following call never reassigns these lines
		@(posedge i_sys_clk);
	endtask
	task automatic clear(input int n);
		o_bus.clr_n <= 1'b0;
		repeat (n) @(posedge i_sys_clk);
		o_bus.clr_n <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
	endtask
endmodule

// ===== hvcbl_top_tb.sv
`timescale 1ns/1ps
// ==================================================
// Bench for the latch board
module hvcbl_top_tb;
	import hvcbl_pkg::*;
	localparam logic [7:0] REV = 8'h3C; // Arbitrary strap value
	logic clk, rst_n, ack_n_out, ack_oe, data_oe, gain, hv, zblk, osc_n;
	logic [7:0] data_out, relay_n;
	logic [3:0] tap, mux;
	logic [1:0] aux;
	hvcbl_bus_t bus;
	int error_cnt, compares;
	// Pull-up on ack; design wins the data lines while reading
	wire ack_n = ack_oe ? ack_n_out : 1'b1;
	wire [7:0] dbus = data_oe ? data_out : bus.data;
	hvcbl_top i_hvcbl_top (.i_sys_clk(clk), .i_rst_n(rst_n),
		.i_guarded_addr(bus.addr), .i_guarded_data(dbus),
		.i_guarded_write_strobe_n(bus.wr_n),
		.i_guarded_read_strobe_n(bus.rd_n),
		.i_guarded_power_on_clear_n(bus.clr_n), .i_rev_strap(REV),
		.o_ack_n_out(ack_n_out), .o_ack_oe(ack_oe), .o_data_out(data_out),
		.o_data_oe(data_oe), .o_relay_drive_n(relay_n), .o_tap_select(tap),
		.o_zero_amp_gain_select(gain), .o_hv_drive_enable(hv),
		.o_zero_input_relay_block(zblk), .o_osc_reset_n(osc_n),
		.o_aux_relay_ctl(aux), .o_mon_mux_sel(mux));
	hvcbl_host_model i_hvcbl_host_model (.i_sys_clk(clk), .i_ack_n(ack_n),
		.i_bus_data(dbus), .o_bus(bus));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [7:0] e, g);
		compares++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic [6:0] a, input logic [7:0] d,
		input logic wr, e);
		logic [7:0] q;
		logic ok;
		i_hvcbl_host_model.xfer(a, d, wr, q, ok);
		chk("ack", 8'(e), 8'(ok));
		if (!wr && e) chk("rev", REV, q);
	endtask
	task automatic give_verdict;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		error_cnt = 0;
		compares = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk("reset", 8'hFF, relay_n);
		xfer(ADDR_RELAY, 8'hA5, 1'b1, 1'b1);
		chk("relay", 8'h5A, relay_n);
		xfer(ADDR_RELAY, 8'hA4, 1'b1, 1'b1);
		chk("polarity", 8'h01, 8'(relay_n[0]));
		for (int i = 0; i < 4; i++)
		begin
			xfer(ADDR_CTRL, 8'h60 | 8'(1 << i) | 8'(i % 2 << 4), 1'b1, 1'b1);
			chk("tap", 8'(1 << i), 8'(tap));
			chk("gain", 8'(i % 2), 8'(gain));
			chk("hv", 8'h07, {5'h0, hv, zblk, osc_n});
		end
		xfer(ADDR_CTRL, 8'h4F, 1'b1, 1'b1);
		chk("hv", 8'h0F, {hv, zblk, osc_n, 1'b0, tap});
		xfer(ADDR_AUX, 8'hFE, 1'b1, 1'b1);
		chk("aux", 8'h02, 8'(aux));
		xfer(ADDR_MUX, 8'hF6, 1'b1, 1'b1);
		chk("mux", 8'h06, 8'(mux));
		xfer(ADDR_REV, 8'hFF, 1'b1, 1'b1);
		xfer(7'h7F, 8'hFF, 1'b1, 1'b0);
		chk("keep", 8'h5B, relay_n);
		chk("keep", 8'h86, {aux, 2'b0, mux});
		xfer(ADDR_REV, 8'h00, 1'b0, 1'b1);
		xfer(7'h7F, 8'h00, 1'b0, 1'b0);
		i_hvcbl_host_model.clear(6);
		chk("clear", 8'hFF, relay_n);
		chk("clear", 8'h00, {aux, 2'b0, mux});
		chk("clear", 8'h00, {hv, zblk, osc_n, gain, tap});
		give_verdict();
	end
endmodule
